// file: hdl/crpc_pkg.sv
package crpc_pkg;
  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CRPC_SRC_FAST_RC,
    CRPC_SRC_MAIN,
    CRPC_SRC_SUB,
    CRPC_SRC_SLOW_RC
  } crpc_src_t;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CRPC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] CRPC_ADDR_FREQ = 4'h1;
  localparam logic [3:0] CRPC_ADDR_STAT = 4'h2;
  localparam logic [3:0] CRPC_ADDR_CAUSE = 4'h3;
  localparam logic [3:0] CRPC_ADDR_SWRST = 4'h4;

  // Control register fields
  localparam int CRPC_CTRL_SEL_LO = 0;
  localparam int CRPC_CTRL_MAIN_STOP = 2;
  localparam int CRPC_CTRL_FAST_STOP = 3;
  localparam int CRPC_CTRL_SUB_STOP = 4;
  localparam int CRPC_CTRL_SLOW_WDT = 5;
  localparam int CRPC_CTRL_SLOW_RTC = 6;
  localparam int CRPC_CTRL_SLOW_ITV = 7;
  localparam logic [7:0] CRPC_CTRL_RESET = 8'h00;

  // Fast RC frequency code, 0 means follow option byte
  localparam logic [2:0] CRPC_FREQ_MAX = 3'h5;
  localparam logic [7:0] CRPC_SWRST_KEY = 8'ha5;

  // Reset cause bit order
  localparam int CRPC_NCAUSE = 7;
  localparam int CRPC_C_PIN = 0;
  localparam int CRPC_C_WDT = 1;
  localparam int CRPC_C_POR = 2;
  localparam int CRPC_C_SLD = 3;
  localparam int CRPC_C_PAR = 4;
  localparam int CRPC_C_ILL = 5;
  localparam int CRPC_C_SW = 6;

  // Main crystal settling time
  localparam int CRPC_CLK_MHZ = 100;
  localparam int CRPC_XTAL_SETTLE_US = 100;
  localparam int CRPC_XTAL_SETTLE_CYC = CRPC_XTAL_SETTLE_US * CRPC_CLK_MHZ;
  localparam int CRPC_RESET_STRETCH = 2;
  localparam logic [15:0] CRPC_BOOT_VEC_ADDR = 16'h0000;

  typedef struct packed {
    logic run_fast;
    logic run_main;
    logic run_sub;
    logic cpu_gate;
  } crpc_clk_ctl_t;
endpackage : crpc_pkg

// file: hdl/crpc_top.sv
`timescale 1ns/100ps
// Behaviour
// R01: After internal reset, the CPU clock source is the fast internal RC oscillator.
// R02: Fast RC oscillator stops on deep sleep or its stop bit.
// R03: Fast RC frequency follows option byte until software writes a selection, max 64 MHz.
// R04: Main crystal oscillator stops on deep sleep or main stop bit.
// R05: External main clock is blocked on deep sleep or main stop bit.
// R06: Sub crystal oscillator stops whenever the sub stop bit is set.
// R07: External sub clock is blocked whenever the sub stop bit is set.
// R08: Slow RC selectable as CPU clock and for watchdog, RTC, interval timer.
// R09: Sleep instruction gates only the CPU clock.
// R10: Oscillators running before sleep keep running in sleep.
// R11: Deep sleep stops main crystal and fast RC, halting the system.
// R12: An interrupt request ends deep sleep and restarts operation.
// R13: Leaving deep sleep on main crystal waits the settling time first.
// R14: Both low-power modes keep registers, flags, memory and port latches.
// R15: Seven reset causes merge into one internal reset.
// R16: Asserting the external reset pin resets the whole system.
// R17: RAM parity error triggers internal reset.
// R18: Illegal memory access triggers internal reset.
// R19: Watchdog runaway detection triggers internal reset.
// R20: Power-down detect asserts reset; release only after power-up level reached.
// R21: Supply detector gives reset or interrupt per option byte, active in deep sleep.
// R22: All resets act alike; boot fetches the vector at address zero.
// R23: External reset pin is active low, tied high when unused.
// R24: Internal reset asserts asynchronously, releases synchronously.
// R25: CPU clock switch changes over only while old and new clocks are low.
module crpc_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ext_reset_n_pin_in,
  input wire logic wdt_runaway_in,
  input wire logic below_power_down_in,
  input wire logic above_power_up_in,
  input wire logic supply_low_in,
  input wire logic opt_supply_reset_in,
  input wire logic ram_parity_err_in,
  input wire logic illegal_access_in,
  input wire logic [2:0] opt_fast_freq_in,
  input wire logic sleep_req_in,
  input wire logic deep_sleep_req_in,
  input wire logic irq_pending_in,
  input wire logic fast_rc_clk_in,
  input wire logic main_xtal_in,
  input wire logic main_xtal_out_or_ext_clk_in,
  input wire logic main_ext_mode_in,
  input wire logic sub_xtal_in,
  input wire logic sub_xtal_out_or_ext_clk_in,
  input wire logic sub_ext_mode_in,
  input wire logic slow_rc_clk_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic sys_reset_out,
  output logic [15:0] boot_vec_addr_out,
  output logic cpu_clk_en_out,
  output logic cpu_clk_out,
  output logic [1:0] cpu_src_out,
  output logic fast_rc_en_out,
  output logic [2:0] fast_rc_freq_out,
  output logic main_xtal_en_out,
  output logic main_clk_out,
  output logic sub_xtal_en_out,
  output logic sub_clk_out,
  output logic wdt_clk_out,
  output logic rtc_clk_out,
  output logic itv_clk_out,
  output logic supply_irq_out,
  output logic sleeping_out,
  output logic deep_sleeping_out
);
  // ----------------------------------------------------------------
  // Reset merge
  // ----------------------------------------------------------------
  logic [6:0] cause_now;
  logic [6:0] cause;
  logic sw_reset_req;
  logic por_hold;
  logic raw_reset;
  logic [1:0] rst_sync;
  logic int_rst;

  // R20 power window
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      por_hold <= 1'b1;
    end else if (below_power_down_in) begin
      por_hold <= 1'b1;
    end else if (above_power_up_in) begin
      por_hold <= 1'b0;
    end
  end

  always_comb begin
    cause_now = '0;
    // R16 pin reset, R23 active low
    cause_now[crpc_pkg::CRPC_C_PIN] = ~ext_reset_n_pin_in;
    // R19 watchdog cause
    cause_now[crpc_pkg::CRPC_C_WDT] = wdt_runaway_in;
    cause_now[crpc_pkg::CRPC_C_POR] = por_hold | below_power_down_in;
    // R21 detector as reset
    cause_now[crpc_pkg::CRPC_C_SLD] = supply_low_in & opt_supply_reset_in;
    // R17 parity cause
    cause_now[crpc_pkg::CRPC_C_PAR] = ram_parity_err_in;
    // R18 illegal access cause
    cause_now[crpc_pkg::CRPC_C_ILL] = illegal_access_in;
    cause_now[crpc_pkg::CRPC_C_SW] = sw_reset_req;
  end

  // R15 seven causes merged
  assign raw_reset = rst_in | (|cause_now);

  // R24 async assert, sync release
  always_ff @(posedge clk_in or posedge raw_reset) begin
    if (raw_reset) begin
      rst_sync <= 2'b11;
    end else begin
      rst_sync <= {rst_sync[0], 1'b0};
    end
  end
  assign int_rst = rst_sync[1];

  // Cause log survives internal reset; rst_in clears it, a CAUSE write clears the bits written as ones
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cause <= '0;
    end else if (wr_in && addr_in == crpc_pkg::CRPC_ADDR_CAUSE) begin
      cause <= (cause & ~wdata_in[6:0]) | cause_now;
    end else begin
      cause <= cause | cause_now;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [2:0] freq_sel;
  logic freq_written;

  // R14 ctrl only reset, never cleared by low-power modes
  always_ff @(posedge clk_in or posedge int_rst) begin
    if (int_rst) begin
      ctrl <= crpc_pkg::CRPC_CTRL_RESET;
    end else if (wr_in && addr_in == crpc_pkg::CRPC_ADDR_CTRL) begin
      ctrl <= wdata_in;
    end
  end

  // R03 option byte then register
  always_ff @(posedge clk_in or posedge int_rst) begin
    if (int_rst) begin
      freq_sel <= '0;
      freq_written <= 1'b0;
    end else if (wr_in && addr_in == crpc_pkg::CRPC_ADDR_FREQ) begin
      freq_written <= wdata_in[2:0] != '0;
      freq_sel <= (wdata_in[2:0] > crpc_pkg::CRPC_FREQ_MAX) ?
                  crpc_pkg::CRPC_FREQ_MAX : wdata_in[2:0];
    end
  end

  // Software reset needs a key so stray writes do no harm
  // Cleared by rst_in only, so the request stands one cycle and is logged
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sw_reset_req <= 1'b0;
    end else begin
      sw_reset_req <= wr_in && addr_in == crpc_pkg::CRPC_ADDR_SWRST &&
                      wdata_in == crpc_pkg::CRPC_SWRST_KEY;
    end
  end

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CRPC_RUN,
    CRPC_SLEEP,
    CRPC_DEEP,
    CRPC_SETTLE
  } crpc_mode_t;
  crpc_mode_t mode;
  logic [13:0] settle_cnt;
  logic [1:0] sel;
  assign sel = ctrl[crpc_pkg::CRPC_CTRL_SEL_LO +: 2];

  always_ff @(posedge clk_in or posedge int_rst) begin
    if (int_rst) begin
      mode <= CRPC_RUN;
      settle_cnt <= '0;
    end else begin
      case (mode)
        CRPC_RUN: begin
          if (deep_sleep_req_in) begin
            mode <= CRPC_DEEP;
          end else if (sleep_req_in) begin
            mode <= CRPC_SLEEP;
          end
        end
        CRPC_SLEEP: begin
          if (irq_pending_in) begin
            mode <= CRPC_RUN;
          end
        end
        CRPC_DEEP: begin
          // R12 interrupt wakes
          if (irq_pending_in) begin
            // R13 crystal settling
            if (sel == 2'(crpc_pkg::CRPC_SRC_MAIN) && !main_ext_mode_in) begin
              mode <= CRPC_SETTLE;
              settle_cnt <= 14'(crpc_pkg::CRPC_XTAL_SETTLE_CYC - 1);
            end else begin
              mode <= CRPC_RUN;
            end
          end
        end
        CRPC_SETTLE: begin
          if (settle_cnt == '0) begin
            mode <= CRPC_RUN;
          end else begin
            settle_cnt <= settle_cnt - 14'h0001;
          end
        end
        default: mode <= CRPC_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables
  // ----------------------------------------------------------------
  crpc_pkg::crpc_clk_ctl_t cc;
  always_comb begin
    // R02 R11 fast RC stop
    cc.run_fast = !ctrl[crpc_pkg::CRPC_CTRL_FAST_STOP] && mode != CRPC_DEEP;
    // R04 R05 R11 main stop, R10 sleep keeps it
    cc.run_main = !ctrl[crpc_pkg::CRPC_CTRL_MAIN_STOP] && mode != CRPC_DEEP;
    // R06 R07 sub stop only by bit
    cc.run_sub = !ctrl[crpc_pkg::CRPC_CTRL_SUB_STOP];
    // R09 only CPU gated
    cc.cpu_gate = mode == CRPC_RUN;
  end

  logic main_src;
  logic sub_src;
  logic new_clk;
  assign main_src = main_ext_mode_in ? main_xtal_out_or_ext_clk_in : main_xtal_in;
  assign sub_src = sub_ext_mode_in ? sub_xtal_out_or_ext_clk_in : sub_xtal_in;

  always_comb begin
    case (sel)
      2'(crpc_pkg::CRPC_SRC_MAIN): new_clk = main_src & cc.run_main;
      2'(crpc_pkg::CRPC_SRC_SUB): new_clk = sub_src & cc.run_sub;
      // R08 slow RC as CPU clock
      2'(crpc_pkg::CRPC_SRC_SLOW_RC): new_clk = slow_rc_clk_in;
      default: new_clk = fast_rc_clk_in & cc.run_fast;
    endcase
  end

  // R25 glitch-free changeover
  logic [1:0] cur_src;
  logic cur_clk;
  always_comb begin
    case (cur_src)
      2'(crpc_pkg::CRPC_SRC_MAIN): cur_clk = main_src & cc.run_main;
      2'(crpc_pkg::CRPC_SRC_SUB): cur_clk = sub_src & cc.run_sub;
      2'(crpc_pkg::CRPC_SRC_SLOW_RC): cur_clk = slow_rc_clk_in;
      default: cur_clk = fast_rc_clk_in & cc.run_fast;
    endcase
  end

  // R01 fast RC after reset
  always_ff @(posedge clk_in or posedge int_rst) begin
    if (int_rst) begin
      cur_src <= 2'(crpc_pkg::CRPC_SRC_FAST_RC);
    end else if (sel != cur_src && !cur_clk && !new_clk) begin
      cur_src <= sel;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge int_rst) begin
    if (int_rst) begin
      cpu_clk_en_out <= 1'b0;
      cpu_clk_out <= 1'b0;
      cpu_src_out <= 2'(crpc_pkg::CRPC_SRC_FAST_RC);
      fast_rc_en_out <= 1'b1;
      fast_rc_freq_out <= '0;
      main_xtal_en_out <= 1'b1;
      main_clk_out <= 1'b0;
      sub_xtal_en_out <= 1'b1;
      sub_clk_out <= 1'b0;
      wdt_clk_out <= 1'b0;
      rtc_clk_out <= 1'b0;
      itv_clk_out <= 1'b0;
      sleeping_out <= 1'b0;
      deep_sleeping_out <= 1'b0;
      supply_irq_out <= 1'b0;
    end else begin
      cpu_clk_en_out <= cc.cpu_gate;
      cpu_clk_out <= cur_clk & cc.cpu_gate;
      cpu_src_out <= cur_src;
      fast_rc_en_out <= cc.run_fast;
      fast_rc_freq_out <= freq_written ? freq_sel : opt_fast_freq_in;
      main_xtal_en_out <= cc.run_main;
      main_clk_out <= main_src & cc.run_main;
      sub_xtal_en_out <= cc.run_sub;
      sub_clk_out <= sub_src & cc.run_sub;
      // R08 peripheral slow clocks
      wdt_clk_out <= ctrl[crpc_pkg::CRPC_CTRL_SLOW_WDT] ? slow_rc_clk_in : sub_src & cc.run_sub;
      rtc_clk_out <= ctrl[crpc_pkg::CRPC_CTRL_SLOW_RTC] ? slow_rc_clk_in : sub_src & cc.run_sub;
      itv_clk_out <= ctrl[crpc_pkg::CRPC_CTRL_SLOW_ITV] ? slow_rc_clk_in : sub_src & cc.run_sub;
      sleeping_out <= mode == CRPC_SLEEP;
      deep_sleeping_out <= mode == CRPC_DEEP || mode == CRPC_SETTLE;
      // R21 detector as interrupt, live in deep sleep
      supply_irq_out <= supply_low_in & !opt_supply_reset_in;
    end
  end

  // R22 reset vector at zero
  always_ff @(posedge clk_in or posedge raw_reset) begin
    if (raw_reset) begin
      sys_reset_out <= 1'b1;
      boot_vec_addr_out <= crpc_pkg::CRPC_BOOT_VEC_ADDR;
    end else begin
      sys_reset_out <= int_rst;
      boot_vec_addr_out <= crpc_pkg::CRPC_BOOT_VEC_ADDR;
    end
  end

  // Read data one cycle after strobe
  always_ff @(posedge clk_in or posedge int_rst) begin
    if (int_rst) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        crpc_pkg::CRPC_ADDR_CTRL: rdata_out <= ctrl;
        crpc_pkg::CRPC_ADDR_FREQ: rdata_out <= {5'h00, fast_rc_freq_out};
        crpc_pkg::CRPC_ADDR_STAT: rdata_out <= {4'h0, mode == CRPC_SETTLE, cur_src == sel, cur_src};
        crpc_pkg::CRPC_ADDR_CAUSE: rdata_out <= {1'b0, cause};
        default: rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  fast_stop_deep_a: assert property (@(posedge clk_in) disable iff (int_rst) // R11
    mode == CRPC_DEEP |=> !fast_rc_en_out && !main_xtal_en_out)
    else $error("oscillators run in deep sleep");
  sub_stop_bit_a: assert property (@(posedge clk_in) disable iff (int_rst) // R06
    ctrl[crpc_pkg::CRPC_CTRL_SUB_STOP] |=> !sub_xtal_en_out && !sub_clk_out)
    else $error("sub oscillator not stopped");
  sleep_keeps_a: assert property (@(posedge clk_in) disable iff (int_rst) // R10
    mode == CRPC_SLEEP && !ctrl[crpc_pkg::CRPC_CTRL_FAST_STOP] |=> fast_rc_en_out)
    else $error("fast rc stopped in sleep");
  sleep_gates_a: assert property (@(posedge clk_in) disable iff (int_rst) // R09
    mode == CRPC_RUN && sleep_req_in && !deep_sleep_req_in ##1 1'b1 |=> !cpu_clk_en_out)
    else $error("cpu clock not gated in sleep");
  deep_wake_a: assert property (@(posedge clk_in) disable iff (int_rst) // R12
    mode == CRPC_DEEP && irq_pending_in |=> mode != CRPC_DEEP)
    else $error("deep sleep not left on interrupt");
  settle_wait_a: assert property (@(posedge clk_in) disable iff (int_rst) // R13
    mode == CRPC_SETTLE |=> !cpu_clk_en_out)
    else $error("cpu ran during settling");
  parity_reset_a: assert property (@(posedge clk_in) // R17
    ram_parity_err_in |=> sys_reset_out)
    else $error("parity error gave no reset");
  switch_low_a: assert property (@(posedge clk_in) disable iff (int_rst) // R25
    cur_src != $past(cur_src) |-> !$past(cur_clk) && !$past(new_clk))
    else $error("clock switched while high");
endmodule : crpc_top

// file: bench/crpc_osc_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Oscillator model, a stopped source holds low
// ----------------------------------------------------------------
module crpc_osc_model (
  input wire logic clk_in,
  input wire logic fast_en_in,
  input wire logic main_en_in,
  input wire logic sub_en_in,
  output logic fast_out,
  output logic main_out,
  output logic main_ext_out,
  output logic sub_out,
  output logic sub_ext_out,
  output logic slow_out
);
  logic [3:0] cnt = 4'h0;
  always_ff @(posedge clk_in) begin
    cnt <= cnt + 4'h1;
  end
  assign fast_out = fast_en_in & cnt[0];
  assign main_out = main_en_in & cnt[1];
  assign main_ext_out = main_en_in & cnt[2];
  assign sub_out = sub_en_in & cnt[3];
  assign sub_ext_out = sub_en_in & cnt[2];
  assign slow_out = cnt[3];
endmodule : crpc_osc_model

// file: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk, rst, pin_n, wdt, below, above, sup_low, opt_rst, par, ill, slp, dslp, irq;
  logic m_ext, s_ext, wr, rd, f_clk, m_clk, m_xclk, s_clk, s_xclk, l_clk, sys_rst, cen;
  logic cclk, fen, men, mclk, sen, sclk, wclk, rclk, iclk, sirq, sleeping, deep;
  logic [2:0] opt_freq, freq;
  logic [3:0] addr, pv, nv;
  logic [7:0] wdata, rdata;
  logic [15:0] vec;
  logic [1:0] src;
  int error_cnt, checked, n, i, k;
  int tg[4];
  crpc_top i_dut (.clk_in(clk), .rst_in(rst), .ext_reset_n_pin_in(pin_n),
    .wdt_runaway_in(wdt), .below_power_down_in(below), .above_power_up_in(above),
    .supply_low_in(sup_low), .opt_supply_reset_in(opt_rst), .ram_parity_err_in(par),
    .illegal_access_in(ill), .opt_fast_freq_in(opt_freq), .sleep_req_in(slp),
    .deep_sleep_req_in(dslp), .irq_pending_in(irq), .fast_rc_clk_in(f_clk),
    .main_xtal_in(m_clk), .main_xtal_out_or_ext_clk_in(m_xclk), .main_ext_mode_in(m_ext),
    .sub_xtal_in(s_clk), .sub_xtal_out_or_ext_clk_in(s_xclk), .sub_ext_mode_in(s_ext),
    .slow_rc_clk_in(l_clk), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .sys_reset_out(sys_rst), .boot_vec_addr_out(vec),
    .cpu_clk_en_out(cen), .cpu_clk_out(cclk), .cpu_src_out(src), .fast_rc_en_out(fen),
    .fast_rc_freq_out(freq), .main_xtal_en_out(men), .main_clk_out(mclk),
    .sub_xtal_en_out(sen), .sub_clk_out(sclk), .wdt_clk_out(wclk), .rtc_clk_out(rclk),
    .itv_clk_out(iclk), .supply_irq_out(sirq), .sleeping_out(sleeping),
    .deep_sleeping_out(deep));
  crpc_osc_model i_osc (.clk_in(clk), .fast_en_in(fen), .main_en_in(men), .sub_en_in(sen),
    .fast_out(f_clk), .main_out(m_clk), .main_ext_out(m_xclk), .sub_out(s_clk),
    .sub_ext_out(s_xclk), .slow_out(l_clk));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task cmp1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp1
  task cmpv(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmpv
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmpv(16'(rdata), 16'(e));
  endtask : rd_chk
  function automatic logic sig(input int s);
    case (s)
      0: return sys_rst;
      1: return sleeping;
      2: return cen;
      3: return deep;
      4: return src === 2'h3;
      5: return src === 2'h1;
      default: return src === 2'h0;
    endcase
  endfunction : sig
  // Bounded wait, runs out into the closing report
  task wait_on(input int s, input logic v);
    int j;
    for (j = 0; j < 60 && sig(s) !== v; j++) begin
      @(posedge clk);
      #1;
    end
    cmp1(sig(s), v);
    if (j == 60) stop_test();
  endtask : wait_on
  task pulse(input logic deep_req);
    @(posedge clk);
    if (deep_req) dslp <= 1'b1;
    else slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    dslp <= 1'b0;
  endtask : pulse
  task cause(input int c, input logic v);
    @(posedge clk);
    case (c)
      0: pin_n <= !v;
      1: wdt <= v;
      2: begin
        below <= v;
        if (v) above <= 1'b0;
      end
      3: sup_low <= v;
      4: par <= v;
      5: ill <= v;
      default: ;
    endcase
  endtask : cause
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_defaults;
    cmpv(16'(src), 16'(crpc_pkg::CRPC_SRC_FAST_RC));
    cmpv(vec, crpc_pkg::CRPC_BOOT_VEC_ADDR);
    cmpv(16'(freq), 16'(opt_freq));
    rd_chk(crpc_pkg::CRPC_ADDR_CTRL, crpc_pkg::CRPC_CTRL_RESET);
    rd_chk(4'hf, 8'h00);
  endtask : t_defaults
  task t_freq;
    wr_reg(crpc_pkg::CRPC_ADDR_FREQ, 8'h03);
    repeat (2) @(posedge clk);
    #1 cmpv(16'(freq), 16'h0003);
    wr_reg(crpc_pkg::CRPC_ADDR_FREQ, 8'h07);
    repeat (2) @(posedge clk);
    #1 cmpv(16'(freq), 16'(crpc_pkg::CRPC_FREQ_MAX));
    wr_reg(crpc_pkg::CRPC_ADDR_FREQ, 8'h00);
    repeat (2) @(posedge clk);
    #1 cmpv(16'(freq), 16'(opt_freq));
  endtask : t_freq
  task t_stops;
    m_ext <= 1'b1;
    s_ext <= 1'b1;
    wr_reg(crpc_pkg::CRPC_ADDR_CTRL, 8'hff);
    wait_on(4, 1'b1);
    rd_chk(crpc_pkg::CRPC_ADDR_STAT, 8'h07);
    repeat (2) @(posedge clk);
    #1 cmp1(fen, 1'b0);
    cmp1(men, 1'b0);
    cmp1(mclk, 1'b0);
    cmp1(sen, 1'b0);
    cmp1(sclk, 1'b0);
    tg = '{0, 0, 0, 0};
    pv = {cclk, wclk, rclk, iclk};
    repeat (80) begin
      @(posedge clk);
      #1;
      nv = {cclk, wclk, rclk, iclk};
      for (k = 0; k < 4; k++) tg[k] += int'(pv[k] !== nv[k]);
      pv = nv;
    end
    for (k = 0; k < 4; k++) cmp1(tg[k] > 0, 1'b1);
    m_ext <= 1'b0;
    s_ext <= 1'b0;
    wr_reg(crpc_pkg::CRPC_ADDR_CTRL, 8'h00);
    wait_on(6, 1'b1);
  endtask : t_stops
  task t_sleep;
    pulse(1'b0);
    wait_on(1, 1'b1);
    repeat (2) @(posedge clk);
    #1 cmp1(cen, 1'b0);
    cmp1(fen & men & sen, 1'b1);
    rd_chk(crpc_pkg::CRPC_ADDR_CTRL, 8'h00);
    irq <= 1'b1;
    wait_on(1, 1'b0);
    irq <= 1'b0;
    wait_on(2, 1'b1);
  endtask : t_sleep
  task t_deep;
    wr_reg(crpc_pkg::CRPC_ADDR_CTRL, 8'h01);
    wait_on(5, 1'b1);
    wr_reg(crpc_pkg::CRPC_ADDR_FREQ, 8'h03);
    pulse(1'b1);
    wait_on(3, 1'b1);
    sup_low <= 1'b1;
    repeat (3) @(posedge clk);
    #1 cmp1(fen | men | cen, 1'b0);
    cmp1(sirq, 1'b1);
    cmp1(sys_rst, 1'b0);
    sup_low <= 1'b0;
    irq <= 1'b1;
    for (n = 0; n < 20000 && cen !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    irq <= 1'b0;
    cmp1(n < 20000, 1'b1);
    if (n == 20000) stop_test();
    n -= crpc_pkg::CRPC_XTAL_SETTLE_CYC;
    cmp1(n >= 0 && n <= 10, 1'b1);
    rd_chk(crpc_pkg::CRPC_ADDR_CTRL, 8'h01);
    rd_chk(crpc_pkg::CRPC_ADDR_FREQ, 8'h03);
    wr_reg(crpc_pkg::CRPC_ADDR_CTRL, 8'h00);
    wait_on(6, 1'b1);
  endtask : t_deep
  task t_resets;
    opt_rst <= 1'b1;
    for (i = 0; i < crpc_pkg::CRPC_NCAUSE; i++) begin
      wr_reg(crpc_pkg::CRPC_ADDR_CTRL, 8'h10);
      wr_reg(crpc_pkg::CRPC_ADDR_CAUSE, 8'h7f);
      if (i == crpc_pkg::CRPC_C_SW) begin
        wr_reg(crpc_pkg::CRPC_ADDR_SWRST, crpc_pkg::CRPC_SWRST_KEY);
      end else begin
        cause(i, 1'b1);
        #2 cmp1(sys_rst, 1'b1);
      end
      wait_on(0, 1'b1);
      cause(i, 1'b0);
      if (i == crpc_pkg::CRPC_C_POR) begin
        repeat (10) @(posedge clk);
        #1 cmp1(sys_rst, 1'b1);
        above <= 1'b1;
      end
      wait_on(0, 1'b0);
      repeat (3) @(posedge clk);
      rd_chk(crpc_pkg::CRPC_ADDR_CAUSE, 8'h01 << i);
      rd_chk(crpc_pkg::CRPC_ADDR_CTRL, 8'h00);
      cmp1(sen, 1'b1);
      cmpv(16'(src), 16'h0000);
    end
    opt_rst <= 1'b0;
  endtask : t_resets
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #1ms;
    error_cnt++;
    stop_test();
  end
  initial begin
    error_cnt = 0;
    checked = 0;
    rst = 1'b1;
    pin_n = 1'b1;
    {wdt, below, sup_low, opt_rst, par, ill, slp, dslp, irq} = '0;
    {m_ext, s_ext, wr, rd} = '0;
    above = 1'b1;
    opt_freq = 3'h2;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wait_on(0, 1'b0);
    repeat (3) @(posedge clk);
    t_defaults();
    t_freq();
    t_stops();
    t_sleep();
    t_deep();
    t_resets();
    stop_test();
  end
endmodule : testbench
